// *** rtl/pg_ack_pkg.sv ***
/*
  Constants shared by the acknowledgment and request framer: frame identifier
  fields, data length codes, acknowledgment control codes and byte fillers.
  Assumes a CAN controller outside that splits the 29-bit identifier into
  priority, data page, format, specific and source fields.
*/
`default_nettype none

package pg_ack_pkg;

  // identifier fields
  localparam logic [2:0]  PRIO_DEFAULT = 3'h6;
  localparam logic        DATA_PAGE    = 1'h0;
  localparam logic [7:0]  PF_ACK       = 8'he8;   // group 0x00e800
  localparam logic [7:0]  PF_REQ       = 8'hea;   // group 0x00ea00
  localparam logic [7:0]  ADDR_GLOBAL  = 8'hff;
  localparam logic [23:0] PGN_ACK      = 24'h00e800;
  localparam logic [23:0] PGN_REQ      = 24'h00ea00;

  // lengths
  localparam logic [3:0]  DLC_ACK      = 4'h8;
  localparam logic [3:0]  DLC_REQ      = 4'h3;

  // payload contents
  localparam logic [7:0]  BYTE_FILL    = 8'hff;
  localparam logic [7:0]  GFV_MAX      = 8'hfa;
  localparam logic [5:0]  CTRL_PAD     = 6'h00;
  localparam logic [7:0]  CTRL_LAST    = 8'h03;

  // byte lanes of the 64-bit payload, byte 1 in the low lane
  localparam int          LANE_CTRL    = 0;
  localparam int          LANE_GFV     = 8;
  localparam int          LANE_RESV    = 16;
  localparam int          LANE_PGN     = 40;

  // acknowledgment outcome
  typedef enum logic [1:0] {
    ACK_POSITIVE = 2'h0,
    ACK_NEGATIVE = 2'h1,
    ACK_DENIED   = 2'h2,
    ACK_BUSY     = 2'h3
  } ack_ctrl_e;

endpackage

`default_nettype wire

// *** rtl/pgn_bytes_pack.sv ***
/*
  Places a 24-bit group number into three payload bytes, least significant
  byte first, bit 8 of each byte most significant.
  Assumes the caller registers the result where it meets an output.
*/
`default_nettype none

module pgn_bytes_pack
(
  // group number in
  input  wire logic [23:0] pgn,
  // payload bytes out, first byte in the low lane
  output logic      [23:0] bytes
);

  // least significant byte goes first on the wire
  assign bytes = {pgn[23:16], pgn[15:8], pgn[7:0]};

endmodule

`default_nettype wire

// *** rtl/pgn_bytes_unpack.sv ***
/*
  Reassembles a 24-bit group number from three received payload bytes sent
  least significant byte first.
  Assumes the payload lanes hold byte 1 in the low bits.
*/
`default_nettype none

module pgn_bytes_unpack
(
  // payload bytes in, first byte in the low lane
  input  wire logic [23:0] bytes,
  // group number out
  output logic      [23:0] pgn
);

  // first byte is the least significant
  assign pgn = {bytes[23:16], bytes[15:8], bytes[7:0]};

endmodule

`default_nettype wire

// *** rtl/pg_ack_framer.sv ***
/*
  Acknowledgment and request framer. Decodes received request frames, hands
  the asked-for group number to the application, and builds the eight-byte
  acknowledgment frame for whatever received group is awaiting one.
  Assumes a CAN controller on both sides that presents whole frames with a
  split identifier, a synchronous application, and one clock mclk.
*/
`default_nettype none

module pg_ack_framer
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // own node address
  input  wire logic [7:0]  own_addr,
  // received frame from the can controller
  input  wire logic        rx_valid,
  input  wire logic [2:0]  rx_prio,
  input  wire logic        rx_dp,
  input  wire logic [7:0]  rx_pf,
  input  wire logic [7:0]  rx_ps,
  input  wire logic [7:0]  rx_sa,
  input  wire logic [3:0]  rx_dlc,
  input  wire logic [63:0] rx_data,
  // decoded request towards the application
  output logic             req_valid,
  output logic [23:0]      req_pgn,
  output logic [7:0]       req_sa,
  output logic             req_global,
  // other received groups needing acknowledgment
  input  wire logic        arm_valid,
  input  wire logic [23:0] arm_pgn,
  // acknowledgment order from the application
  input  wire logic        ack_valid,
  output logic             ack_ready,
  input  wire pg_ack_pkg::ack_ctrl_e ack_ctrl,
  input  wire logic        ack_gfv_valid,
  input  wire logic [7:0]  ack_gfv,
  // acknowledgment still owed
  output logic             ack_pending,
  // frame to the can controller
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [2:0]       tx_prio,
  output logic             tx_dp,
  output logic [7:0]       tx_pf,
  output logic [7:0]       tx_ps,
  output logic [7:0]       tx_sa,
  output logic [3:0]       tx_dlc,
  output logic [63:0]      tx_data
);

  import pg_ack_pkg::*;

  typedef enum logic {
    TX_IDLE,
    TX_SEND
  } tx_state_e;

  tx_state_e   state_reg;
  tx_state_e   state_next;
  logic        pend_reg;
  logic [23:0] pend_pgn_reg;
  logic        req_hit;
  logic        req_len_ok;
  logic        req_addr_ok;
  logic        accept;
  logic [23:0] rx_pgn;
  logic [23:0] pend_bytes;
  logic [7:0]  gfv_byte;

  // reassemble the requested group number from bytes 1 to 3
  pgn_bytes_unpack i_pgn_bytes_unpack
  (
    .bytes (rx_data[23:0]),
    .pgn   (rx_pgn)
  );

  // order the pending group number for bytes 6 to 8
  pgn_bytes_pack i_pgn_bytes_pack
  (
    .pgn   (pend_pgn_reg),
    .bytes (pend_bytes)
  );

  // request frame recognition, to us or to everyone
  assign req_len_ok  = (rx_dlc == DLC_REQ);
  assign req_addr_ok = (rx_ps == own_addr) || (rx_ps == ADDR_GLOBAL);
  assign req_hit     = rx_valid && (rx_dp == DATA_PAGE) && (rx_pf == PF_REQ)
                       && req_addr_ok && req_len_ok;

  // request handed to the application as a one-cycle pulse
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      req_valid  <= 1'b0;
      req_pgn    <= '0;
      req_sa     <= '0;
      req_global <= 1'b0;
    end
    else
    begin
      req_valid <= req_hit;
      if (req_hit)
      begin
        req_pgn    <= rx_pgn;
        req_sa     <= rx_sa;
        req_global <= (rx_ps == ADDR_GLOBAL);
      end
    end
  end

  // an order is taken only while an acknowledgment is owed
  assign ack_ready   = (state_reg == TX_IDLE) && pend_reg;
  assign accept      = ack_valid && ack_ready;
  assign ack_pending = pend_reg;

  // owed flag: a new arrival wins over the clear by acceptance
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      pend_reg     <= 1'b0;
      pend_pgn_reg <= '0;
    end
    else if (req_hit)
    begin
      pend_reg     <= 1'b1;
      pend_pgn_reg <= rx_pgn;
    end
    else if (arm_valid)
    begin
      pend_reg     <= 1'b1;
      pend_pgn_reg <= arm_pgn;
    end
    else if (accept)
    begin
      pend_reg <= 1'b0;
    end
  end

  // group function byte, out-of-range values sent as not applicable
  always_comb
  begin
    if (ack_gfv_valid && (ack_gfv <= GFV_MAX))
      gfv_byte = ack_gfv;
    else
      gfv_byte = BYTE_FILL;
  end

  // transmit sequencing
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      TX_IDLE:
      begin
        if (accept)
          state_next = TX_SEND;
      end
      TX_SEND:
      begin
        if (tx_ready)
          state_next = TX_IDLE;
      end
      default:
      begin
        state_next = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      state_reg <= TX_IDLE;
    else
      state_reg <= state_next;
  end

  assign tx_valid = (state_reg == TX_SEND);

  // fixed identifier of the acknowledgment frame
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_prio <= PRIO_DEFAULT;
      tx_dp   <= DATA_PAGE;
      tx_pf   <= PF_ACK;
      tx_ps   <= ADDR_GLOBAL;
      tx_sa   <= '0;
      tx_dlc  <= DLC_ACK;
    end
    else if (accept)
    begin
      tx_prio <= PRIO_DEFAULT;
      tx_dp   <= DATA_PAGE;
      tx_pf   <= PF_ACK;
      tx_ps   <= ADDR_GLOBAL;
      tx_sa   <= own_addr;
      tx_dlc  <= DLC_ACK;
    end
  end

  // payload captured on acceptance and held until sent
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      tx_data <= '0;
    else if (accept)
    begin
      tx_data[LANE_CTRL +: 8]  <= {CTRL_PAD, ack_ctrl};
      tx_data[LANE_GFV +: 8]   <= gfv_byte;
      tx_data[LANE_RESV +: 24] <= {3{BYTE_FILL}};
      tx_data[LANE_PGN +: 24]  <= pend_bytes;
    end
  end

  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  property p_ack_only_owed;
    $rose(tx_valid) |-> $past(pend_reg) && $past(ack_valid);
  endproperty
  a_ack_only_owed: assert property (p_ack_only_owed) else $error("ack sent without owed group");

  property p_ack_ident;
    tx_valid |-> (tx_pf == PF_ACK) && (tx_ps == ADDR_GLOBAL) && (tx_prio == PRIO_DEFAULT)
                 && (tx_dlc == DLC_ACK) && (tx_dp == DATA_PAGE);
  endproperty
  a_ack_ident: assert property (p_ack_ident) else $error("ack identifier wrong");

  property p_ctrl_range;
    tx_valid |-> tx_data[LANE_CTRL +: 8] <= CTRL_LAST;
  endproperty
  a_ctrl_range: assert property (p_ctrl_range) else $error("reserved control value sent");

  property p_positive;
    accept && (ack_ctrl == ACK_POSITIVE) |=> tx_valid && (tx_data[LANE_CTRL +: 8] == 8'h00);
  endproperty
  a_positive: assert property (p_positive) else $error("positive ack code wrong");

  property p_negative;
    accept && (ack_ctrl == ACK_NEGATIVE) |=> tx_valid && (tx_data[LANE_CTRL +: 8] == 8'h01);
  endproperty
  a_negative: assert property (p_negative) else $error("negative ack code wrong");

  property p_denied;
    accept && (ack_ctrl == ACK_DENIED) |=> tx_valid && (tx_data[LANE_CTRL +: 8] == 8'h02);
  endproperty
  a_denied: assert property (p_denied) else $error("access denied code wrong");

  property p_busy;
    accept && (ack_ctrl == ACK_BUSY) |=> tx_valid && (tx_data[LANE_CTRL +: 8] == 8'h03);
  endproperty
  a_busy: assert property (p_busy) else $error("busy code wrong");

  property p_gfv_fill;
    accept && !ack_gfv_valid |=> tx_data[LANE_GFV +: 8] == BYTE_FILL;
  endproperty
  a_gfv_fill: assert property (p_gfv_fill) else $error("absent group function not 0xff");

  property p_gfv_range;
    tx_valid |-> (tx_data[LANE_GFV +: 8] <= GFV_MAX) || (tx_data[LANE_GFV +: 8] == BYTE_FILL);
  endproperty
  a_gfv_range: assert property (p_gfv_range) else $error("group function out of range");

  property p_reserved;
    tx_valid |-> tx_data[LANE_RESV +: 24] == {3{BYTE_FILL}};
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bytes not 0xff");

  property p_pgn_order;
    accept |=> (tx_data[LANE_PGN +: 8] == $past(pend_pgn_reg[7:0]))
               && (tx_data[LANE_PGN + 8 +: 8] == $past(pend_pgn_reg[15:8]))
               && (tx_data[LANE_PGN + 16 +: 8] == $past(pend_pgn_reg[23:16]));
  endproperty
  a_pgn_order: assert property (p_pgn_order) else $error("group number byte order wrong");

  property p_bad_len;
    rx_valid && (rx_pf == PF_REQ) && (rx_dlc != DLC_REQ) && !arm_valid && !pend_reg
      |=> !req_valid && !pend_reg;
  endproperty
  a_bad_len: assert property (p_bad_len) else $error("request with wrong length taken");

  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_hold: assert property (p_hold) else $error("ack frame dropped while stalled");

  property p_req_owed;
    req_hit |=> req_valid && ack_pending;
  endproperty
  a_req_owed: assert property (p_req_owed) else $error("request not recorded as owed");

  property p_release;
    tx_valid && tx_ready |=> !tx_valid;
  endproperty
  a_release: assert property (p_release) else $error("ack frame not released after take");

endmodule

`default_nettype wire

// *** verification/pg_ecu_model.sv ***
/*
  far-side ecu: sends request frames, takes acknowledgment frames.
  assumes the bench calls send and sets stall.
*/
`default_nettype none
module pg_ecu_model
(
  // clock
  input  wire logic        mclk,
  // frame towards the framer
  output logic             rx_valid,
  output logic [2:0]       rx_prio,
  output logic             rx_dp,
  output logic [7:0]       rx_pf,
  output logic [7:0]       rx_ps,
  output logic [7:0]       rx_sa,
  output logic [3:0]       rx_dlc,
  output logic [63:0]      rx_data,
  // frame from the framer
  input  wire logic        tx_valid,
  output logic             tx_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  int stall = 0;
  int cnt = 0;
  initial {rx_valid, rx_prio, rx_dp, rx_pf, rx_ps, rx_sa, rx_dlc, rx_data, tx_ready} = '0;
  // one frame held for one edge, then fields scrambled
  // real requesters space frames far apart; the bench compresses that gap
  task automatic send(input logic dp, input logic [7:0] pf, ps, input logic [3:0] dlc, input logic [23:0] pgn);
    @(posedge mclk);
    #1;
    {rx_valid, rx_prio, rx_dp, rx_pf, rx_ps, rx_sa} = {1'b1, 3'h6, dp, pf, ps, 8'h17};
    {rx_dlc, rx_data} = {dlc, {40{1'b1}}, pgn};
    @(posedge mclk);
    #1;
    rx_valid = 1'b0;
    {rx_pf, rx_ps, rx_dlc, rx_data} = ~{rx_pf, rx_ps, rx_dlc, rx_data};
  endtask
  // take a frame after stall cycles
  always @(posedge mclk)
  begin
    #1;
    if (tx_valid && !tx_ready && cnt < stall)
      cnt++;
    else
    begin
      tx_ready = tx_valid && !tx_ready;
      cnt = 0;
    end
  end
endmodule
`default_nettype wire

// *** verification/pg_ack_framer_tb.sv ***
/*
  bench for the framer: requests, refusals, every outcome code.
  assumes the ecu model drives the receive side.
*/
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module pg_ack_framer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pg_ack_pkg::*;
  int num_checks = 0;
  int miscompares = 0;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] own_addr = 8'h2a;
  logic arm_valid = 1'b0;
  logic ack_valid = 1'b0;
  logic ack_gfv_valid = 1'b0;
  logic [23:0] arm_pgn = '0;
  logic [7:0] ack_gfv = '0;
  ack_ctrl_e ack_ctrl = ACK_POSITIVE;
  logic rx_valid, rx_dp, req_valid, req_global, ack_ready, ack_pending, tx_valid, tx_ready, tx_dp;
  logic [2:0] rx_prio, tx_prio;
  logic [7:0] rx_pf, rx_ps, rx_sa, req_sa, tx_pf, tx_ps, tx_sa;
  logic [3:0] rx_dlc, tx_dlc;
  logic [63:0] rx_data, tx_data;
  logic [23:0] req_pgn;
  pg_ack_framer i_pg_ack_framer (.mclk(mclk), .rstn(rstn), .own_addr(own_addr), .rx_valid(rx_valid),
    .rx_prio(rx_prio), .rx_dp(rx_dp), .rx_pf(rx_pf), .rx_ps(rx_ps), .rx_sa(rx_sa), .rx_dlc(rx_dlc),
    .rx_data(rx_data), .req_valid(req_valid), .req_pgn(req_pgn), .req_sa(req_sa), .req_global(req_global),
    .arm_valid(arm_valid), .arm_pgn(arm_pgn), .ack_valid(ack_valid), .ack_ready(ack_ready),
    .ack_ctrl(ack_ctrl), .ack_gfv_valid(ack_gfv_valid), .ack_gfv(ack_gfv), .ack_pending(ack_pending),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_prio(tx_prio), .tx_dp(tx_dp), .tx_pf(tx_pf),
    .tx_ps(tx_ps), .tx_sa(tx_sa), .tx_dlc(tx_dlc), .tx_data(tx_data));
  pg_ecu_model i_pg_ecu_model (.mclk(mclk), .rx_valid(rx_valid), .rx_prio(rx_prio), .rx_dp(rx_dp),
    .rx_pf(rx_pf), .rx_ps(rx_ps), .rx_sa(rx_sa), .rx_dlc(rx_dlc), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready));
  always #20 mclk = ~mclk;
  // one request frame and its decode
  task automatic do_req(input logic dp, input logic [7:0] pf, ps, input logic [3:0] dlc, input logic [23:0] pgn,
                        input logic take);
    logic was;
    was = ack_pending;
    i_pg_ecu_model.send(dp, pf, ps, dlc, pgn);
    `CHK(req_valid, take)
    `CHK(ack_pending, take | was)
    if (take)
    begin
      `CHK(req_pgn, pgn)
      `CHK({req_global, req_sa}, {ps == 8'hff, 8'h17})
    end
    @(posedge mclk);
    #1;
    `CHK(req_valid, 1'b0)
  endtask
  // order an acknowledgment and judge the frame at its handshake
  task automatic do_ack(input ack_ctrl_e c, input logic gv, input logic [7:0] g, eg, input logic [23:0] pgn,
                        input int st);
    int n;
    n = 0;
    i_pg_ecu_model.stall = st;
    ack_valid = 1'b1;
    ack_ctrl = c;
    ack_gfv_valid = gv;
    ack_gfv = g;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (ack_ready !== 1'b1 && n < 20);
    #1;
    ack_valid = 1'b0;
    `CHK({tx_valid, ack_pending}, 2'b10)
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (!(tx_valid === 1'b1 && tx_ready === 1'b1) && n < 20);
    `CHK({tx_prio, tx_dp, tx_pf, tx_ps, tx_sa, tx_dlc}, {3'h6, 1'b0, 8'he8, 8'hff, own_addr, 4'h8})
    `CHK(tx_data[7:0], {6'h0, c})
    `CHK(tx_data[15:8], eg)
    `CHK(tx_data[39:16], 24'hffffff)
    `CHK(tx_data[63:40], pgn)
    #1;
    `CHK(tx_valid, 1'b0)
  endtask
  // every outcome code, group function boundaries, stalling taker
  task automatic t_codes();
    logic [7:0] gt [4] = '{8'h00, 8'hfa, 8'hfb, 8'h12};
    logic [7:0] ge [4] = '{8'h00, 8'hfa, 8'hff, 8'hff};
    for (int c = 0; c < 4; c++)
    begin
      do_req(1'b0, 8'hea, own_addr, 4'h3, 24'h01fe00 + 24'(c), 1'b1);
      do_ack(ack_ctrl_e'(c), c != 3, gt[c], ge[c], 24'h01fe00 + 24'(c), c);
    end
  endtask
  // malformed or foreign frames leave nothing owed
  task automatic t_refuse();
    do_req(1'b0, 8'hea, own_addr, 4'h2, 24'h00fecb, 1'b0);
    do_req(1'b0, 8'hea, own_addr, 4'h4, 24'h00fecb, 1'b0);
    do_req(1'b0, 8'heb, own_addr, 4'h3, 24'h00fecb, 1'b0);
    do_req(1'b1, 8'hea, own_addr, 4'h3, 24'h00fecb, 1'b0);
    do_req(1'b0, 8'hea, 8'h2b, 4'h3, 24'h00fecb, 1'b0);
    ack_valid = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    ack_valid = 1'b0;
    `CHK({ack_ready, tx_valid}, 2'b00)
  endtask
  // global request, then an armed group replaces the owed one
  task automatic t_global_arm();
    do_req(1'b0, 8'hea, 8'hff, 4'h3, 24'h00fee5, 1'b1);
    do_ack(ACK_BUSY, 1'b1, 8'h07, 8'h07, 24'h00fee5, 0);
    do_req(1'b0, 8'hea, 8'hff, 4'h3, 24'h00fee5, 1'b1);
    {arm_valid, arm_pgn} = {1'b1, 24'h03f004};
    @(posedge mclk);
    #1;
    arm_valid = 1'b0;
    do_ack(ACK_NEGATIVE, 1'b0, 8'h00, 8'hff, 24'h03f004, 1);
  endtask
  // counts and verdict
  task automatic results();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // reset, scenarios, verdict
  initial
  begin
    repeat (5) @(posedge mclk);
    `CHK({tx_valid, ack_pending, req_valid, tx_pf, tx_dlc}, {3'b000, 8'he8, 4'h8})
    #1;
    rstn = 1'b1;
    t_codes();
    t_refuse();
    t_global_arm();
    results();
  end
  // watchdog
  initial
  begin
    #100000;
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
